// File: include/adc_ctrl_pkg.sv
// Shared constants and types for the converter control block.
// Assumes a 250 MHz system clock; all pins are sampled on it.
package adc_ctrl_pkg;
    // Timing, figures in ns, counts derived from the clock period
    localparam int CLK_PERIOD_NS = 4;
    localparam int PWRUP_NS = 1000;
    localparam int CONV_NS = 2000;
    localparam int PWRUP_CYC = (PWRUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CONV_CYC = CONV_NS / CLK_PERIOD_NS;
    localparam int TMR_W = 9;
    localparam logic [TMR_W-1:0] PWRUP_LIM = TMR_W'(PWRUP_CYC);
    localparam logic [TMR_W-1:0] CONV_LAST = TMR_W'(CONV_CYC - 1);
    // Bus addresses
    localparam logic [2:0] ADDR_FIXED = 3'h2;
    localparam logic [6:0] ARA_ADDR = 7'h0C;
    localparam logic [4:0] HS_CODE = 5'h01;
    // Pointer values
    localparam logic [3:0] PTR_RESULT = 4'h0;
    localparam logic [3:0] PTR_ALERT = 4'h1;
    localparam logic [3:0] PTR_CONFIG = 4'h2;
    localparam logic [3:0] PTR_CYCLE = 4'h3;
    localparam logic [3:0] PTR_LO1 = 4'h4;
    localparam logic [3:0] PTR_HI1 = 4'h5;
    localparam logic [3:0] PTR_HY1 = 4'h6;
    localparam logic [3:0] PTR_LO2 = 4'h7;
    localparam logic [3:0] PTR_HI2 = 4'h8;
    localparam logic [3:0] PTR_HY2 = 4'h9;
    // Configuration bit positions
    localparam int CFG_POL = 0;
    localparam int CFG_CLR = 1;
    localparam int CFG_EN = 2;
    localparam int CFG_BUSY = 3;
    localparam int CFG_CH1 = 4;
    localparam int CFG_CH2 = 5;
    // Result word bit positions
    localparam int RES_ALERT = 15;
    localparam int RES_INVALID = 14;
    localparam int RES_CH = 12;
    // Values after reset
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [7:0] CYC_RESET = 8'h00;
    localparam logic [3:0] PTR_RESET = 4'h0;
    localparam logic [11:0] LOW_RESET = 12'h000;
    localparam logic [11:0] HIGH_RESET = 12'hFFF;
    localparam logic [11:0] HYST_RESET = 12'h000;

    typedef struct packed {
        logic [11:0] hyst;
        logic [11:0] high;
        logic [11:0] low;
    } lim_entry_t;

    // Field is one-hot: bit 0 low, bit 1 high, bit 2 hysteresis
    typedef struct packed {
        logic we;
        logic ch;
        logic [2:0] field;
        logic [11:0] data;
    } lim_wr_t;

    localparam lim_entry_t LIM_RESET = '{hyst: HYST_RESET, high: HIGH_RESET,
                                         low: LOW_RESET};

    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_ADDR = 6'h02,
        ST_ACK = 6'h04,
        ST_WRX = 6'h08,
        ST_RTX = 6'h10,
        ST_RACK = 6'h20
    } i2c_st_t;

    typedef enum logic [2:0] {
        CV_SLEEP = 3'h1,
        CV_PWRUP = 3'h2,
        CV_CONV = 3'h4
    } cv_st_t;
endpackage : adc_ctrl_pkg

// File: logic/limit_mem.sv
// Limit and hysteresis store, one entry per channel, two read ports.
// Assumes writes from the serial side; read data are registered.
`timescale 1ns/10ps
module limit_mem
    import adc_ctrl_pkg::*;
(
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire lim_wr_t wr_i,
    input wire logic rd_a_i,
    output lim_entry_t rd_a_o,
    input wire logic rd_b_i,
    output lim_entry_t rd_b_o
);
    typedef struct packed {
        lim_entry_t [1:0] ent;
        lim_entry_t a;
        lim_entry_t b;
    } mem_state_t;

    localparam mem_state_t MEM_RESET = '{ent: {LIM_RESET, LIM_RESET},
                                         a: LIM_RESET, b: LIM_RESET};

    mem_state_t s;
    mem_state_t next_s;

    // Field writes per entry, then registered reads
    always_comb
    begin
        next_s = s;
        for (int i = 0; i < 2; i++)
        begin
            if (wr_i.we && wr_i.ch == 1'(i))
            begin
                if (wr_i.field[0])
                    next_s.ent[i].low = wr_i.data;
                if (wr_i.field[1])
                    next_s.ent[i].high = wr_i.data;
                if (wr_i.field[2])
                    next_s.ent[i].hyst = wr_i.data;
            end
        end
        next_s.a = s.ent[rd_a_i];
        next_s.b = s.ent[rd_b_i];
    end

    // State register
    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
            s <= MEM_RESET;
        else
            s <= next_s;
    end

    assign rd_a_o = s.a;
    assign rd_b_o = s.b;
endmodule : limit_mem

// File: logic/adc_readback_alert_conversion_start_n_ctrl.sv
// Serial readback, limit alert and pin-started conversion control.
// Assumes bus pins and start pin are asynchronous; converter data
// arrive on clk_i and are valid at the end of a conversion.
// Operation
// - Status, configuration and cycle registers read back as one byte.
// - Pointer keeps its value across reads until rewritten.
// - Result, limit and hysteresis registers read back as two bytes.
// - Further acknowledged reads keep returning fresh register content.
// - Shared output selectable as limit alert or busy indicator.
// - Alert output drives only low, otherwise floats.
// - Configuration bit 0 sets alert polarity; active low after reset.
// - Configuration bit 2 disables (0) or enables (1) the alert.
// - Alert response address acknowledged only while asserting alert.
// - Alert response byte arbitrates normally; lowest address wins.
// - Alert when selected channel's result exceeds upper or undercuts lower.
// - Configuration write with bit 1 set clears an active alert.
// - Alert clears when result returns hysteresis counts inside limit.
// - High speed master code is never acknowledged.
// - High speed mode holds until STOP, then fast mode again.
// - Converter sleeps after reset and whenever not powering up or converting.
// - Start pin rising edge powers up; master holds it high 1 us.
// - Falling edge holds and converts; shutdown about 2 us later.
// - High time of 1 us or less marks the result invalid.
// - Configuration bits 4 and 5 select channels; both alternate.
// - Slave address top bits are 010; rest from version and pin.
`timescale 1ns/10ps
module adc_readback_alert_conversion_start_n_ctrl
    import adc_ctrl_pkg::*;
#(
    parameter logic [2:0] ADDR_MID = 3'h0 // Version bits, value arbitrary
)
(
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic address_select_pin_i,
    input wire logic conversion_start_n_i,
    input wire logic [11:0] conv_data_i,
    output logic alert_o,
    output logic alert_oe_o,
    output logic adc_power_o,
    output logic adc_hold_o,
    output logic adc_channel_o,
    output logic hs_mode_o,
    output logic [3:0] pointer_command_o,
    output logic [7:0] cycle_timer_o
);
    typedef struct packed {
        i2c_st_t ist;
        cv_st_t cst;
        logic [2:0] scl_s;
        logic [2:0] sda_s;
        logic [2:0] cs_s;
        logic [1:0] as_s;
        logic [7:0] sh;
        logic [2:0] bitcnt;
        logic rw;
        logic ackd;
        logic ara;
        logic hs;
        logic first;
        logic hi;
        logic oe;
        logic [7:0] wr_hi;
        logic [3:0] ptr;
        logic [3:0] cmd;
        logic [7:0] cfg;
        logic [7:0] cyc;
        logic [3:0] alst;
        logic [15:0] result;
        logic ch;
        logic seq;
        logic inv;
        logic cmp;
        logic pin_oe;
        logic [TMR_W-1:0] tmr;
    } state_t;

    localparam state_t ST_RESET = '{ist: ST_IDLE, cst: CV_SLEEP,
                                    ptr: PTR_RESET, cfg: CFG_RESET,
                                    cyc: CYC_RESET, default: '0};

    state_t st;
    state_t next_st;
    logic scl_r, scl_f, start_c, stop_c, sda_v, cs_rise, cs_fall;
    logic alert_act, pin_act, two, ch_a, clr_cfg, clr_ara, load_tx;
    logic [7:0] rx, txb;
    logic [15:0] word;
    logic [6:0] own;
    logic [2:0] fsel;
    logic [3:0] set_v, clr_v;
    lim_wr_t wr;
    lim_entry_t ent_a, ent_b;

    limit_mem u_mem (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .wr_i(wr),
        .rd_a_i(ch_a),
        .rd_a_o(ent_a),
        .rd_b_i(st.ch),
        .rd_b_o(ent_b)
    );

    // Edges seen on the second synchroniser stage only
    assign sda_v = st.sda_s[1];
    assign scl_r = st.scl_s[1] & ~st.scl_s[2];
    assign scl_f = ~st.scl_s[1] & st.scl_s[2];
    assign start_c = st.scl_s[1] & st.scl_s[2] & ~sda_v & st.sda_s[2];
    assign stop_c = st.scl_s[1] & st.scl_s[2] & sda_v & ~st.sda_s[2];
    assign cs_rise = st.cs_s[1] & ~st.cs_s[2];
    assign cs_fall = ~st.cs_s[1] & st.cs_s[2];
    assign rx = {st.sh[6:0], sda_v};
    assign own = {ADDR_FIXED, ADDR_MID, st.as_s[1]};
    assign alert_act = (|st.alst) & st.cfg[CFG_EN] & ~st.cfg[CFG_BUSY];
    assign pin_act = st.cfg[CFG_BUSY] ? (st.cst == CV_CONV) : alert_act;
    assign ch_a = st.ptr >= PTR_LO2;
    assign load_tx = next_st.ist == ST_RTX && st.ist != ST_RTX;

    // Readback byte for the selected register
    always_comb
    begin
        word = 16'h0000;
        two = 1'b0;
        case (st.ptr)
            PTR_RESULT:
            begin
                word = st.result;
                two = 1'b1;
            end
            PTR_ALERT: word = {12'h000, st.alst};
            PTR_CONFIG: word = {8'h00, st.cfg};
            PTR_CYCLE: word = {8'h00, st.cyc};
            PTR_LO1, PTR_LO2:
            begin
                word = {4'h0, ent_a.low};
                two = 1'b1;
            end
            PTR_HI1, PTR_HI2:
            begin
                word = {4'h0, ent_a.high};
                two = 1'b1;
            end
            PTR_HY1, PTR_HY2:
            begin
                word = {4'h0, ent_a.hyst};
                two = 1'b1;
            end
            default: word = 16'h0000;
        endcase
        if (st.ara)
            txb = {own, 1'b0};
        else if (two && st.hi)
            txb = word[15:8];
        else
            txb = word[7:0];
        if (st.ptr == PTR_LO1 || st.ptr == PTR_LO2)
            fsel = 3'h1;
        else if (st.ptr == PTR_HI1 || st.ptr == PTR_HI2)
            fsel = 3'h2;
        else
            fsel = 3'h4;
    end

    // Next state: serial slave, conversion sequencer, alert flags
    always_comb
    begin
        next_st = st;
        wr = '0;
        clr_cfg = 1'b0;
        clr_ara = 1'b0;
        set_v = 4'h0;
        clr_v = 4'h0;
        next_st.scl_s = {st.scl_s[1:0], scl_i};
        next_st.sda_s = {st.sda_s[1:0], sda_i};
        next_st.cs_s = {st.cs_s[1:0], conversion_start_n_i};
        next_st.as_s = {st.as_s[0], address_select_pin_i};
        next_st.cmp = 1'b0;
        if (stop_c)
        begin
            next_st.ist = ST_IDLE;
            next_st.oe = 1'b0;
            next_st.ara = 1'b0;
            next_st.hs = 1'b0;
        end
        else if (start_c)
        begin
            next_st.ist = ST_ADDR;
            next_st.bitcnt = 3'h0;
            next_st.oe = 1'b0;
            next_st.ara = 1'b0;
        end
        else
        begin
            unique case (st.ist)
                ST_IDLE: next_st.ist = ST_IDLE;
                ST_ADDR:
                    if (scl_r)
                    begin
                        next_st.sh = rx;
                        next_st.bitcnt = 3'(st.bitcnt + 3'h1);
                        if (st.bitcnt == 3'h7)
                        begin
                            next_st.rw = sda_v;
                            next_st.ackd = 1'b0;
                            next_st.hi = 1'b1;
                            next_st.first = 1'b1;
                            if (rx[7:3] == HS_CODE)
                            begin
                                next_st.hs = 1'b1;
                                next_st.ist = ST_IDLE;
                            end
                            else if (rx[7:1] == own)
                                next_st.ist = ST_ACK;
                            else if (rx[7:1] == ARA_ADDR && sda_v && alert_act)
                            begin
                                next_st.ara = 1'b1;
                                next_st.ist = ST_ACK;
                            end
                            else
                                next_st.ist = ST_IDLE;
                        end
                    end
                ST_ACK:
                    if (scl_f && !st.ackd)
                    begin
                        next_st.oe = 1'b1;
                        next_st.ackd = 1'b1;
                    end
                    else if (scl_f)
                    begin
                        next_st.bitcnt = 3'h0;
                        next_st.oe = 1'b0;
                        next_st.ist = ST_WRX;
                        if (st.rw)
                        begin
                            next_st.ist = ST_RTX;
                            next_st.sh = txb;
                            next_st.oe = ~txb[7];
                        end
                    end
                ST_WRX:
                    if (scl_r)
                    begin
                        next_st.sh = rx;
                        next_st.bitcnt = 3'(st.bitcnt + 3'h1);
                        if (st.bitcnt == 3'h7)
                        begin
                            next_st.ist = ST_ACK;
                            next_st.ackd = 1'b0;
                            if (st.first)
                            begin
                                next_st.ptr = rx[3:0];
                                next_st.cmd = rx[7:4];
                                next_st.first = 1'b0;
                                next_st.hi = 1'b1;
                            end
                            else if (st.ptr == PTR_CONFIG)
                            begin
                                next_st.cfg = rx;
                                next_st.cfg[CFG_CLR] = 1'b0;
                                clr_cfg = rx[CFG_CLR];
                            end
                            else if (st.ptr == PTR_CYCLE)
                                next_st.cyc = rx;
                            else if (st.ptr >= PTR_LO1 && st.ptr <= PTR_HY2)
                            begin
                                next_st.hi = ~st.hi;
                                next_st.wr_hi = rx;
                                wr.we = ~st.hi;
                                wr.ch = ch_a;
                                wr.field = fsel;
                                wr.data = {st.wr_hi[3:0], rx};
                            end
                        end
                    end
                ST_RTX:
                    if (scl_r && st.ara && st.sh[7] && !sda_v)
                    begin
                        next_st.ist = ST_IDLE;
                        next_st.oe = 1'b0;
                    end
                    else if (scl_f && st.bitcnt == 3'h7)
                    begin
                        next_st.oe = 1'b0;
                        next_st.ackd = 1'b0;
                        next_st.ist = ST_RACK;
                    end
                    else if (scl_f)
                    begin
                        next_st.sh = {st.sh[6:0], 1'b0};
                        next_st.oe = ~st.sh[6];
                        next_st.bitcnt = 3'(st.bitcnt + 3'h1);
                    end
                ST_RACK:
                    if (scl_r && !st.ackd)
                    begin
                        clr_ara = st.ara;
                        if (sda_v || st.ara)
                            next_st.ist = ST_IDLE;
                        else
                        begin
                            next_st.ackd = 1'b1;
                            next_st.hi = ~st.hi;
                        end
                    end
                    else if (scl_f && st.ackd)
                    begin
                        next_st.ist = ST_RTX;
                        next_st.sh = txb;
                        next_st.oe = ~txb[7];
                        next_st.bitcnt = 3'h0;
                    end
                default: next_st.ist = ST_IDLE;
            endcase
        end

        // Pin-started conversion
        unique case (st.cst)
            CV_SLEEP:
                if (cs_rise)
                begin
                    next_st.cst = CV_PWRUP;
                    next_st.tmr = '0;
                end
            CV_PWRUP:
            begin
                if (st.tmr <= PWRUP_LIM)
                    next_st.tmr = TMR_W'(st.tmr + 1'b1);
                if (cs_fall)
                begin
                    next_st.cst = CV_CONV;
                    next_st.tmr = '0;
                    next_st.inv = st.tmr < PWRUP_LIM;
                    next_st.ch = st.cfg[CFG_CH2];
                    if (st.cfg[CFG_CH1] && st.cfg[CFG_CH2])
                    begin
                        next_st.ch = st.seq;
                        next_st.seq = ~st.seq;
                    end
                end
            end
            CV_CONV:
            begin
                next_st.tmr = TMR_W'(st.tmr + 1'b1);
                if (st.tmr == CONV_LAST)
                begin
                    next_st.cst = CV_SLEEP;
                    next_st.result = {4'h0, conv_data_i};
                    next_st.result[RES_ALERT] = |st.alst;
                    next_st.result[RES_INVALID] = st.inv;
                    next_st.result[RES_CH] = st.ch;
                    next_st.cmp = ~st.inv;
                end
            end
            default: next_st.cst = CV_SLEEP;
        endcase

        // Limit compare and hysteresis release per channel
        for (int c = 0; c < 2; c++)
        begin
            if (st.cmp && st.ch == 1'(c))
            begin
                set_v[2*c+1] = st.result[11:0] > ent_b.high;
                set_v[2*c] = st.result[11:0] < ent_b.low;
                clr_v[2*c+1] = 13'(st.result[11:0]) + 13'(ent_b.hyst)
                               <= 13'(ent_b.high);
                clr_v[2*c] = 13'(st.result[11:0])
                             >= 13'(ent_b.low) + 13'(ent_b.hyst);
            end
        end
        if (clr_cfg || clr_ara)
            clr_v = 4'hF;
        next_st.alst = (st.alst & ~clr_v) | set_v;
        next_st.pin_oe = pin_act ^ st.cfg[CFG_POL];
    end

    // State register
    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
            st <= ST_RESET;
        else
            st <= next_st;
    end

    // Open-drain pins only ever pull low
    assign sda_o = 1'b0;
    assign sda_oe_o = st.oe;
    assign alert_o = 1'b0;
    assign alert_oe_o = st.pin_oe;
    assign adc_power_o = st.cst != CV_SLEEP;
    assign adc_hold_o = st.cst == CV_CONV;
    assign adc_channel_o = st.ch;
    assign hs_mode_o = st.hs;
    assign pointer_command_o = st.cmd;
    assign cycle_timer_o = st.cyc;

    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    AST_ONE_BYTE: assert property (load_tx && st.ptr == PTR_CONFIG && !st.ara
        |=> st.sh == $past(st.cfg)) else $error("config readback wrong");
    AST_PTR_HOLD: assert property ($changed(st.ptr)
        |-> $past(st.ist == ST_WRX && st.first))
        else $error("pointer changed outside write");
    AST_TWO_BYTE: assert property (load_tx && st.ptr == PTR_RESULT && st.hi
        && !st.ara |=> st.sh == $past(st.result[15:8]))
        else $error("result high byte wrong");
    AST_POL: assert property ((alert_act && !st.cfg[CFG_POL])[*2]
        |-> alert_oe_o) else $error("active low alert not driven");
    AST_EN: assert property ((!st.cfg[CFG_EN] && !st.cfg[CFG_BUSY]
        && !st.cfg[CFG_POL])[*2] |-> !alert_oe_o)
        else $error("disabled alert driven");
    AST_ARA: assert property (st.ist == ST_ADDR ##1 st.ist == ST_ACK && st.ara
        |-> $past(alert_act)) else $error("ARA acked without alert");
    AST_HS: assert property ($rose(st.hs) |-> st.ist == ST_IDLE && !st.oe
        ##1 !st.oe) else $error("master code acknowledged");
    AST_HS_STOP: assert property (stop_c |=> !hs_mode_o)
        else $error("high speed kept after stop");
    AST_WAKE: assert property (st.cst == CV_SLEEP && cs_rise
        |=> adc_power_o ##1 adc_power_o) else $error("no power-up");
    AST_SHUT: assert property ($fell(adc_power_o)
        |-> $past(st.cst == CV_CONV && st.tmr == CONV_LAST))
        else $error("early shutdown");
    AST_INVALID: assert property (st.cst == CV_PWRUP && cs_fall
        && st.tmr < PWRUP_LIM |=> st.inv) else $error("short pulse valid");
    AST_SET: assert property (st.cmp && !st.ch && st.result[11:0] > ent_b.high
        |=> st.alst[1]) else $error("upper limit not flagged");

    COV_RESULT_READ: cover property (load_tx && st.ptr == PTR_RESULT);
    COV_HS: cover property ($rose(st.hs));
    COV_CONV_DONE: cover property (st.cst == CV_CONV ##1 st.cst == CV_SLEEP);
    COV_ALERT: cover property ($rose(alert_act));
endmodule : adc_readback_alert_conversion_start_n_ctrl

// File: test/i2c_master_model.sv
// Behavioural bus master on the far side of the converter control.
// Assumes a pulled-up SDA wire level fed back on sda_i; no stretching.
`timescale 1ns/10ps
module i2c_master_model
(
    input wire logic clk_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_o
);
    // Lines released at time zero
    initial
    begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end

    // One third of an SCL bit period, 10 clocks, ends just after an edge
    task automatic hp();
        repeat (10) @(posedge clk_i);
        #1;
    endtask : hp

    // Start or repeated start, leaves SCL low
    task automatic start();
        sda_o = 1'b1;
        hp();
        scl_o = 1'b1;
        hp();
        sda_o = 1'b0;
        hp();
        scl_o = 1'b0;
        hp();
    endtask : start

    // Stop condition, leaves the bus idle
    task automatic stop();
        sda_o = 1'b0;
        hp();
        scl_o = 1'b1;
        hp();
        sda_o = 1'b1;
        hp();
    endtask : stop

    // One bit: data set mid-low, read at end of high
    task automatic bt(input logic b, output logic r);
        sda_o = b;
        hp();
        scl_o = 1'b1;
        hp();
        r = sda_i;
        scl_o = 1'b0;
        hp();
    endtask : bt

    // Byte plus acknowledge bit; last high means master no-acknowledge
    task automatic xfer(input logic [7:0] d, input logic last,
                        output logic [7:0] q, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
        begin
            bt(d[i], r);
            q[i] = r;
        end
        bt(last, r);
        ack = ~r;
    endtask : xfer
endmodule : i2c_master_model

// File: test/testbench.sv
// Self-checking bench for the converter control block.
// Assumes the master model drives the bus; start pin driven here.
`timescale 1ns/10ps
module testbench;
    import adc_ctrl_pkg::*;
    localparam logic [7:0] WA = {ADDR_FIXED, 3'h0, 1'b1, 1'b0};
    logic clk_i = 1'b0, nrst_i = 1'b0, cs_n = 1'b0;
    logic [11:0] cdata = 12'h000;
    logic sda_oe_o, alert_oe_o, adc_power_o, adc_hold_o, hs_mode_o;
    logic m_scl, m_sda, d_sda, a_pin;
    logic chan;
    logic [3:0] pc;
    logic [7:0] ct;
    wire logic sda = m_sda & (sda_oe_o ? d_sda : 1'b1);
    int n_mismatch = 0, n_checks = 0;
    logic [7:0] q;
    logic a;
    logic [23:0] v;

    // Clock generation
    initial
    begin
        forever #2 clk_i = ~clk_i;
    end

    i2c_master_model bus (.clk_i(clk_i), .sda_i(sda), .scl_o(m_scl),
        .sda_o(m_sda));
    adc_readback_alert_conversion_start_n_ctrl #(.ADDR_MID(3'h0)) DUT (.clk_i(clk_i),
        .nrst_i(nrst_i), .scl_i(m_scl), .sda_i(sda), .sda_o(d_sda),
        .sda_oe_o(sda_oe_o), .address_select_pin_i(1'b1),
        .conversion_start_n_i(cs_n), .conv_data_i(cdata), .alert_o(a_pin),
        .alert_oe_o(alert_oe_o), .adc_power_o(adc_power_o),
        .adc_hold_o(adc_hold_o), .adc_channel_o(chan), .hs_mode_o(hs_mode_o),
        .pointer_command_o(pc), .cycle_timer_o(ct));

    task automatic chk(input string s, input logic [23:0] e,
                       input logic [23:0] g);
        n_checks++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", s, e, g);
        end
    endtask : chk

    // Pointer write plus n data bytes taken from d high byte first
    task automatic wr(input logic [7:0] p, input int n, input logic [15:0] d);
        bus.start();
        bus.xfer(WA, 1'b1, q, a);
        chk("write addr ack", 1, a);
        bus.xfer(p, 1'b1, q, a);
        if (n > 0) bus.xfer(d[15:8], 1'b1, q, a);
        if (n > 1) bus.xfer(d[7:0], 1'b1, q, a);
        bus.stop();
    endtask : wr

    // Read n bytes, last one not acknowledged
    task automatic rd(input int n);
        bus.start();
        bus.xfer(WA | 8'h01, 1'b1, q, a);
        chk("read addr ack", 1, a);
        for (int i = 0; i < n; i++)
        begin
            bus.xfer(8'hFF, i == n - 1, q, a);
            v = {v[15:0], q};
        end
        bus.stop();
    endtask : rd

    // Start pin pulse with given high time, then hold length check
    task automatic conv(input logic [11:0] d, input int hi, input logic b);
        int n;
        n = 0;
        cdata = d;
        cs_n = 1'b1;
        repeat (5) @(posedge clk_i);
        #1 chk("power up", 1, adc_power_o);
        repeat (hi - 5) @(posedge clk_i);
        #1 cs_n = 1'b0;
        repeat (5) @(posedge clk_i);
        #1 chk("hold", 1, adc_hold_o);
        chk("busy", b, alert_oe_o);
        while (adc_hold_o === 1'b1 && n < 600)
        begin
            @(posedge clk_i);
            #1 n++;
        end
        chk("hold length", 1, n >= 498 && n <= 500);
        chk("power down", 0, adc_power_o);
        repeat (4) @(posedge clk_i);
        #1;
    endtask : conv

    task automatic t_cfg();
        wr(PTR_CONFIG, 1, 16'h1400);
        rd(2);
        chk("config repeat", 16'h1414, v[15:0]);
    endtask : t_cfg

    task automatic t_alert();
        wr(PTR_HI1, 2, 16'h0100);
        conv(12'h2AB, 251, 1'b0);
        chk("alert set", 1, alert_oe_o);
        wr(PTR_RESULT, 0, 16'h0000);
        rd(3);
        chk("result bytes", 24'h02AB02, v);
        wr(PTR_CONFIG, 1, 16'h1600);
        chk("alert cleared", 0, alert_oe_o);
        bus.start();
        bus.xfer({ARA_ADDR, 1'b1}, 1'b1, q, a);
        chk("ara refused", 0, a);
        bus.stop();
    endtask : t_alert

    task automatic t_short();
        wr(PTR_CONFIG, 1, 16'h3800);
        wr(PTR_RESULT, 0, 16'h0000);
        chk("command bits", 0, pc);
        conv(12'h050, 250, 1'b1);
        conv(12'h050, 250, 1'b1);
        chk("channel", 1, chan);
        rd(2);
        chk("invalid result", 16'h5050, v[15:0]);
    endtask : t_short

    task automatic t_hs();
        bus.start();
        bus.xfer({HS_CODE, 3'h5}, 1'b1, q, a);
        chk("master code ack", 0, a);
        chk("hs entered", 1, hs_mode_o);
        bus.start();
        bus.xfer(WA, 1'b1, q, a);
        chk("hs addr ack", 1, a);
        bus.stop();
        chk("hs left", 0, hs_mode_o);
    endtask : t_hs

    task automatic summarize();
        $display("Checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : summarize

    // Main sequence after a 10 cycle reset
    initial
    begin
        repeat (10) @(posedge clk_i);
        #1 nrst_i = 1'b1;
        repeat (10) @(posedge clk_i);
        #1 chk("reset state", 0, {alert_oe_o, adc_power_o, hs_mode_o});
        chk("pin and timer", 0, {a_pin, ct});
        t_cfg();
        t_alert();
        t_short();
        t_hs();
        summarize();
    end

    // Watchdog, well beyond the expected run
    initial
    begin
        #200000;
        n_mismatch++;
        summarize();
    end
endmodule : testbench
